// ---- fsc_defines.svh ----
`ifndef FSC_DEFINES_SVH
`define FSC_DEFINES_SVH

// Move-instruction register select that addresses this register
`define FSC_SEL_CODE        4'h1
`define FSC_RESET_VALUE     32'h00000000

// Field positions
`define FSC_BIT_LESS        31
`define FSC_BIT_EQUAL       30
`define FSC_BIT_CARRY       29
`define FSC_BIT_UNORD       28
`define FSC_BIT_SAT         27
`define FSC_BIT_ALT_HALF    26
`define FSC_BIT_DNAN        25
`define FSC_BIT_FLUSH       24
`define FSC_RND_HI          23
`define FSC_RND_LO          22
`define FSC_STRIDE_HI       21
`define FSC_STRIDE_LO       20
`define FSC_RSV_HI_BIT      19
`define FSC_COUNT_HI        18
`define FSC_COUNT_LO        16
`define FSC_TRAP_SUBN_BIT   15
`define FSC_RSV_MID_HI      14
`define FSC_RSV_MID_LO      13
`define FSC_TRAP_HI         12
`define FSC_TRAP_LO         8
`define FSC_STK_SUBN_BIT    7
`define FSC_RSV_LO_HI       6
`define FSC_RSV_LO_LO       5
`define FSC_STK_HI          4
`define FSC_STK_LO          0

// Rounding encodings
`define FSC_RND_NEAREST     2'h0
`define FSC_RND_PLUS_INF    2'h1
`define FSC_RND_MINUS_INF   2'h2
`define FSC_RND_ZERO        2'h3

// Field reset values
`define FSC_DNAN_RESET      1'h0
`define FSC_FLUSH_RESET     1'h0
`define FSC_RND_RESET       2'h0
`define FSC_STRIDE_RESET    2'h0
`define FSC_COUNT_RESET     3'h0
`define FSC_RSV_RESET       5'h00
`define FSC_CMP_RESET       4'h0
`define FSC_STK_RESET       6'h00
`define FSC_STK_WIDTH       6

`endif

// ---- fsc_pkg.sv ----
`default_nettype none

package fsc_pkg;

  // Move-instruction access from the pipeline
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [3:0]  sel;
    logic [31:0] wdata;
  } fsc_access_t;

  // Comparison outcome from the datapath
  typedef struct packed {
    logic valid;
    logic less;
    logic equal;
    logic greater;
    logic unordered;
  } fsc_cmp_t;

  // Exception raises: subnormal, inexact, underflow, overflow, div0, invalid
  typedef struct packed {
    logic subnormal;
    logic inexact;
    logic underflow;
    logic overflow;
    logic divide_zero;
    logic invalid_op;
  } fsc_exc_t;

  // Mode fields steering the datapath
  typedef struct packed {
    logic       default_nan_enable;
    logic       flush_tiny_enable;
    logic [1:0] rounding_select;
    logic [1:0] vector_stride;
    logic [2:0] vector_count;
  } fsc_mode_t;

  // Condition flags: less, equal, carry, unordered
  typedef struct packed {
    logic less;
    logic equal;
    logic carry;
    logic unord;
  } fsc_flags_t;

endpackage : fsc_pkg

`default_nettype wire

// ---- fsc_sticky_bank.sv ----
`timescale 1ns/100ps
`default_nettype none

module fsc_sticky_bank #(
  parameter int WIDTH = 6
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  input  wire logic [WIDTH-1:0] i_set,
  input  wire logic             i_wr,
  input  wire logic [WIDTH-1:0] i_wdata,
  output var  logic [WIDTH-1:0] o_q
);

  logic [WIDTH-1:0] next_q;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_flag
      // Raise beats a same-cycle software clear
      always_comb begin
        next_q[g] = i_set[g] | (i_wr ? i_wdata[g] : o_q[g]);
      end
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_q <= '0;
    end else begin
      o_q <= next_q;
    end
  end

endmodule : fsc_sticky_bank

`default_nettype wire

// ---- fsc_status_control.sv ----
// What this block does
// - Less-than compare sets bit 31, equal sets bit 30; both reset to zero.
// - Bit 29 set on equal, greater or unordered; bit 28 only on unordered.
// - Bit 25 enables default-NaN results; zero after reset.
// - Bit 24 enables flushing tiny values to zero; zero after reset.
// - Bits 23:22 select rounding: 00 nearest, 01 plus, 10 minus, 11 zero.
// - Bits 21:20 hold vector stride, zero after reset.
// - Bits 18:16 hold vector length, zero after reset.
// - Sticky subnormal-input, inexact, underflow flags at bits 7, 4, 3; reset clears.
// - Sticky overflow, divide-by-zero, invalid flags at bits 2, 1, 0; reset clears.
// - With the unit disabled any access to this register (select 1) raises undefined instruction, no effect.
`timescale 1ns/100ps
`default_nettype none

`include "fsc_defines.svh"

module fsc_status_control (
  input  wire logic                 i_clk,
  input  wire logic                 i_reset_n,
  input  wire logic                 i_unit_enable,
  input  wire fsc_pkg::fsc_access_t i_access,
  input  wire fsc_pkg::fsc_cmp_t    i_cmp,
  input  wire fsc_pkg::fsc_exc_t    i_exc,
  output var  logic [31:0]          o_rdata,
  output var  logic                 o_rd_valid,
  output var  logic                 o_wr_done,
  output var  logic                 o_undef,
  output var  fsc_pkg::fsc_mode_t   o_mode,
  output var  fsc_pkg::fsc_flags_t  o_flags,
  output var  logic [5:0]           o_sticky
);

  // Access decode
  logic hit;
  logic accept;
  logic wr_accept;
  logic rd_accept;

  always_comb begin
    hit       = i_access.valid && (i_access.sel == `FSC_SEL_CODE);
    accept    = hit && i_unit_enable;
    wr_accept = accept && i_access.write;
    rd_accept = accept && !i_access.write;
  end

  // Mode fields and reserved preserve bits
  fsc_pkg::fsc_mode_t next_mode;
  logic [4:0]         rsv;
  logic [4:0]         next_rsv;

  always_comb begin
    next_mode = o_mode;
    next_rsv  = rsv;
    if (wr_accept) begin
      next_mode.default_nan_enable = i_access.wdata[`FSC_BIT_DNAN];
      next_mode.flush_tiny_enable  = i_access.wdata[`FSC_BIT_FLUSH];
      next_mode.rounding_select    = i_access.wdata[`FSC_RND_HI:`FSC_RND_LO];
      next_mode.vector_stride      = i_access.wdata[`FSC_STRIDE_HI:`FSC_STRIDE_LO];
      next_mode.vector_count       = i_access.wdata[`FSC_COUNT_HI:`FSC_COUNT_LO];
      // Stored as written; relies on read-modify-write by software
      next_rsv = {i_access.wdata[`FSC_RSV_HI_BIT],
                  i_access.wdata[`FSC_RSV_MID_HI:`FSC_RSV_MID_LO],
                  i_access.wdata[`FSC_RSV_LO_HI:`FSC_RSV_LO_LO]};
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_mode.default_nan_enable <= `FSC_DNAN_RESET;
      o_mode.flush_tiny_enable  <= `FSC_FLUSH_RESET;
      o_mode.rounding_select    <= `FSC_RND_RESET;
      o_mode.vector_stride      <= `FSC_STRIDE_RESET;
      o_mode.vector_count       <= `FSC_COUNT_RESET;
      rsv                       <= `FSC_RSV_RESET;
    end else begin
      o_mode <= next_mode;
      rsv    <= next_rsv;
    end
  end

  // Condition flags: a compare in the same cycle as a write wins,
  // since it is the later event in program order.
  fsc_pkg::fsc_flags_t next_flags;

  always_comb begin
    next_flags = o_flags;
    if (i_cmp.valid) begin
      next_flags.less  = i_cmp.less;
      next_flags.equal = i_cmp.equal;
      next_flags.carry = i_cmp.equal | i_cmp.greater | i_cmp.unordered;
      next_flags.unord = i_cmp.unordered;
    end else if (wr_accept) begin
      next_flags.less  = i_access.wdata[`FSC_BIT_LESS];
      next_flags.equal = i_access.wdata[`FSC_BIT_EQUAL];
      next_flags.carry = i_access.wdata[`FSC_BIT_CARRY];
      next_flags.unord = i_access.wdata[`FSC_BIT_UNORD];
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_flags <= `FSC_CMP_RESET;
    end else begin
      o_flags <= next_flags;
    end
  end

  // Sticky exception flags
  logic [5:0] stk_set;
  logic [5:0] stk_wdata;

  always_comb begin
    stk_set   = {i_exc.subnormal, i_exc.inexact, i_exc.underflow,
                 i_exc.overflow, i_exc.divide_zero, i_exc.invalid_op};
    stk_wdata = {i_access.wdata[`FSC_STK_SUBN_BIT], i_access.wdata[`FSC_STK_HI:`FSC_STK_LO]};
  end

  fsc_sticky_bank #(
    .WIDTH (`FSC_STK_WIDTH)
  ) u_sticky (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_set     (stk_set),
    .i_wr      (wr_accept),
    .i_wdata   (stk_wdata),
    .o_q       (o_sticky)
  );

  // Read image; trap enables and the two top mode bits are never stored
  logic [31:0] image;

  always_comb begin
    image = `FSC_RESET_VALUE;
    image[`FSC_BIT_LESS]                  = o_flags.less;
    image[`FSC_BIT_EQUAL]                 = o_flags.equal;
    image[`FSC_BIT_CARRY]                 = o_flags.carry;
    image[`FSC_BIT_UNORD]                 = o_flags.unord;
    image[`FSC_BIT_DNAN]                  = o_mode.default_nan_enable;
    image[`FSC_BIT_FLUSH]                 = o_mode.flush_tiny_enable;
    image[`FSC_RND_HI:`FSC_RND_LO]        = o_mode.rounding_select;
    image[`FSC_STRIDE_HI:`FSC_STRIDE_LO]  = o_mode.vector_stride;
    image[`FSC_RSV_HI_BIT]                = rsv[4];
    image[`FSC_COUNT_HI:`FSC_COUNT_LO]    = o_mode.vector_count;
    image[`FSC_RSV_MID_HI:`FSC_RSV_MID_LO] = rsv[3:2];
    image[`FSC_STK_SUBN_BIT]              = o_sticky[5];
    image[`FSC_RSV_LO_HI:`FSC_RSV_LO_LO]  = rsv[1:0];
    image[`FSC_STK_HI:`FSC_STK_LO]        = o_sticky[4:0];
  end

  // Access answer
  logic [31:0] next_rdata;
  logic        next_rd_valid;
  logic        next_wr_done;
  logic        next_undef;

  always_comb begin
    next_rdata    = o_rdata;
    next_rd_valid = rd_accept;
    next_wr_done  = wr_accept;
    next_undef    = hit && !i_unit_enable;
    if (rd_accept) begin
      next_rdata = image;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata    <= `FSC_RESET_VALUE;
      o_rd_valid <= 1'h0;
      o_wr_done  <= 1'h0;
      o_undef    <= 1'h0;
    end else begin
      o_rdata    <= next_rdata;
      o_rd_valid <= next_rd_valid;
      o_wr_done  <= next_wr_done;
      o_undef    <= next_undef;
    end
  end

endmodule : fsc_status_control

`default_nettype wire

// ---- fsc_status_control_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module fsc_status_control_chk (
  input wire logic                 i_clk,
  input wire logic                 i_reset_n,
  input wire logic                 i_unit_enable,
  input wire fsc_pkg::fsc_access_t i_access,
  input wire fsc_pkg::fsc_cmp_t    i_cmp,
  input wire fsc_pkg::fsc_exc_t    i_exc,
  input wire logic [31:0]          o_rdata,
  input wire logic                 o_rd_valid,
  input wire logic                 o_wr_done,
  input wire logic                 o_undef,
  input wire fsc_pkg::fsc_mode_t   o_mode,
  input wire fsc_pkg::fsc_flags_t  o_flags,
  input wire logic [5:0]           o_sticky
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  logic hit;
  assign hit = i_access.valid && i_access.sel == 4'h1;
  sequence s_rd; hit && i_unit_enable && !i_access.write; endsequence
  sequence s_wr; hit && i_unit_enable && i_access.write; endsequence
  // Read shows the image from before any same-cycle write
  property p_rd; s_rd |=> o_rd_valid && {o_rdata[25:20], o_rdata[18:16]} == $past(o_mode); endproperty
  property p_wr; s_wr |=> o_wr_done && o_mode == {$past(i_access.wdata[25:20]), $past(i_access.wdata[18:16])}; endproperty
  property p_undef; hit && !i_unit_enable |=> o_undef && !o_rd_valid && !o_wr_done && $stable(o_mode); endproperty
  property p_raz; o_rd_valid |-> (o_rdata & 32'h0C009F00) == 32'h00000000; endproperty
  property p_cmp;
    i_cmp.valid |=> o_flags == {$past(i_cmp.less), $past(i_cmp.equal),
      $past(i_cmp.equal) | $past(i_cmp.greater) | $past(i_cmp.unordered), $past(i_cmp.unordered)};
  endproperty
  property p_set; (|i_exc) |=> (o_sticky & $past(i_exc)) == $past(i_exc); endproperty
  property p_keep; !(hit && i_access.write) && i_exc == 6'h00 |=> $stable(o_sticky); endproperty
  property p_idle; !hit && !i_cmp.valid |=> !o_rd_valid && !o_wr_done && $stable(o_flags) && $stable(o_mode); endproperty
  a_rd: assert property (p_rd) else $error("read data or valid wrong");
  a_wr: assert property (p_wr) else $error("write not applied");
  a_undef: assert property (p_undef) else $error("disabled access completed");
  a_raz: assert property (p_raz) else $error("zero-read bits set");
  a_cmp: assert property (p_cmp) else $error("compare flags wrong");
  a_set: assert property (p_set) else $error("sticky flag not set");
  a_keep: assert property (p_keep) else $error("sticky flag changed");
  a_idle: assert property (p_idle) else $error("state moved without cause");
endmodule : fsc_status_control_chk
bind fsc_status_control fsc_status_control_chk u_chk (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_unit_enable(i_unit_enable), .i_access(i_access),
  .i_cmp(i_cmp), .i_exc(i_exc), .o_rdata(o_rdata), .o_rd_valid(o_rd_valid), .o_wr_done(o_wr_done),
  .o_undef(o_undef), .o_mode(o_mode), .o_flags(o_flags), .o_sticky(o_sticky));
`default_nettype wire

// ---- fsc_pipe_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module fsc_pipe_model (
  input  wire logic                 i_clk,
  input  wire logic [31:0]          i_rdata,
  output var  fsc_pkg::fsc_access_t o_access,
  output var  fsc_pkg::fsc_cmp_t    o_cmp,
  output var  fsc_pkg::fsc_exc_t    o_exc
);
  initial begin
    o_access = '0;
    o_cmp = '0;
    o_exc = '0;
  end
  task automatic acc(input logic w, input logic [3:0] s, input logic [31:0] d, output logic [31:0] q);
    @(negedge i_clk);
    o_access = '{1'h1, w, s, d};
    @(negedge i_clk);
    q = i_rdata;
    // Stale data is scrambled so nothing leans on it
    o_access = '{1'h0, 1'h0, 4'h0, ~d};
  endtask : acc
  task automatic cmp(input logic [3:0] oh);
    @(negedge i_clk);
    o_cmp = {1'h1, oh};
    @(negedge i_clk);
    o_cmp = '0;
  endtask : cmp
  task automatic exc(input logic [5:0] e);
    @(negedge i_clk);
    o_exc = e;
    @(negedge i_clk);
    o_exc = '0;
  endtask : exc
  // Later updates keep the preserve bits as read
  task automatic rmw(input logic [31:0] m, input logic [31:0] v);
    logic [31:0] q;
    acc(1'h0, 4'h1, 32'h0, q);
    acc(1'h1, 4'h1, (q & ~m) | v, q);
  endtask : rmw
endmodule : fsc_pipe_model
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic                 i_clk = 1'h0;
  logic                 i_reset_n = 1'h0;
  logic                 i_unit_enable = 1'h1;
  fsc_pkg::fsc_access_t acc;
  fsc_pkg::fsc_cmp_t    cmp;
  fsc_pkg::fsc_exc_t    exc;
  logic [31:0]          rdata;
  logic                 rd_valid;
  logic                 wr_done;
  logic                 undef;
  fsc_pkg::fsc_mode_t   mode;
  fsc_pkg::fsc_flags_t  flags;
  logic [5:0]           sticky;
  logic [31:0]          q;
  logic [3:0]           fx [4] = '{4'h8, 4'h6, 4'h2, 4'h3};
  logic [31:0]          rows [8][2] = '{'{32'h00C00000, 32'h00C00000}, '{32'h00400000, 32'h00400000},
    '{32'h00800000, 32'h00800000}, '{32'h02000000, 32'h02000000}, '{32'h01000000, 32'h01000000},
    '{32'h00370000, 32'h00370000}, '{32'hFFFFFFFF, 32'hF3FF60FF}, '{32'h00000000, 32'h00000000}};
  int                   miscompares = 0;
  int                   checks_done = 0;
  int                   cycles = 0;
  fsc_status_control uut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_unit_enable(i_unit_enable),
    .i_access(acc), .i_cmp(cmp), .i_exc(exc), .o_rdata(rdata), .o_rd_valid(rd_valid),
    .o_wr_done(wr_done), .o_undef(undef), .o_mode(mode), .o_flags(flags), .o_sticky(sticky));
  fsc_pipe_model pm (.i_clk(i_clk), .i_rdata(rdata), .o_access(acc), .o_cmp(cmp), .o_exc(exc));
  always #25 i_clk = ~i_clk;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  // Whole run is about a hundred cycles
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    repeat (16) @(posedge i_clk);
    @(negedge i_clk) i_reset_n = 1'h1;
    chk({13'h0, mode, flags, sticky}, 32'h0);
    pm.acc(1'h0, 4'h1, 32'h0, q);
    chk(q, 32'h0);
    pm.acc(1'h1, 4'h1, 32'h0, q);
    for (int i = 0; i < 8; i++) begin
      pm.acc(1'h1, 4'h1, rows[i][0], q);
      pm.acc(1'h0, 4'h1, 32'h0, q);
      chk(q, rows[i][1]);
    end
    for (int i = 0; i < 4; i++) begin
      pm.cmp(4'h8 >> i);
      pm.acc(1'h0, 4'h1, 32'h0, q);
      chk({28'h0, q[31:28]}, {28'h0, fx[i]});
    end
    pm.acc(1'h1, 4'h1, 32'h0, q);
    for (int i = 0; i < 6; i++) begin
      pm.exc(6'h20 >> i);
      chk({26'h0, sticky}, {26'h0, 6'h3F & ~(6'h3F >> (i + 1))});
    end
    pm.acc(1'h0, 4'h1, 32'h0, q);
    chk(q, 32'h0000009F);
    pm.rmw(32'h0000001F, 32'h0);
    chk({26'h0, sticky}, 32'h20);
    // Raise and clearing write land on one edge
    fork
      pm.acc(1'h1, 4'h1, 32'h0, q);
      pm.exc(6'h01);
    join
    chk({26'h0, sticky}, 32'h01);
    i_unit_enable = 1'h0;
    pm.acc(1'h1, 4'h1, 32'hFFFFFFFF, q);
    chk({31'h0, undef}, 32'h1);
    pm.acc(1'h0, 4'h1, 32'h0, q);
    chk({31'h0, rd_valid}, 32'h0);
    i_unit_enable = 1'h1;
    pm.acc(1'h1, 4'h2, 32'hFFFFFFFF, q);
    chk({31'h0, wr_done}, 32'h0);
    pm.acc(1'h0, 4'h1, 32'h0, q);
    chk(q, 32'h00000001);
    // Compare beats a same-cycle write of the flag bits
    fork
      pm.acc(1'h1, 4'h1, 32'hF0000000, q);
      pm.cmp(4'h4);
    join
    chk({28'h0, flags}, 32'h6);
    // Mid-run reset must clear fields that hold ones
    pm.acc(1'h1, 4'h1, 32'hFFFFFFFF, q);
    i_reset_n = 1'h0;
    @(negedge i_clk) i_reset_n = 1'h1;
    chk({13'h0, mode, flags, sticky}, 32'h0);
    pm.acc(1'h0, 4'h1, 32'h0, q);
    chk(q, 32'h0);
    summarize();
  end
endmodule : tb
`default_nettype wire
